// *** verilog/mcm_config_mgmt.sv ***
// Strap decoding, strap latching and management registers of the media converter.
`timescale 1ns/10ps
`default_nettype none
module mcm_config_mgmt (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        por_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic [1:0]  addr_strap_upper_i,
	input  wire logic [1:0]  addr_strap_mid_i,
	input  wire logic [1:0]  addr_strap_low_i,
	input  wire logic [1:0]  speed_strap_i,
	input  wire logic [1:0]  duplex_strap_i,
	input  wire logic [1:0]  copper_iface_select_i,
	input  wire logic [1:0]  fiber_iface_select_i,
	input  wire logic        power_down_n_i,
	input  wire logic        copper_tx_off_n_i,
	input  wire logic        fiber_tx_off_n_i,
	input  wire logic        backup_link_sel_i,
	output logic      [4:0]  station_address_o,
	output logic      [2:0]  op_mode_o,
	output logic             liw_enable_o,
	output logic      [1:0]  copper_iface_o,
	output logic      [1:0]  fiber_iface_o,
	output logic             power_down_o,
	output logic             loop_fiber_o,
	output logic             loop_copper_o,
	output logic             copper_tx_off_o,
	output logic             fiber_tx_off_o,
	output logic             backup_link_o
);

	logic [mcm_pkg::SYNC_W-1:0] raw;
	logic [mcm_pkg::SYNC_W-1:0] sync1_r;
	logic [mcm_pkg::SYNC_W-1:0] sync2_r;

	logic        mdc_s;
	logic        mdio_s;
	logic        por_s;
	logic        pd_n_s;
	logic        cu_off_n_s;
	logic        fo_off_n_s;
	logic        backup_s;
	logic [1:0]  up_s;
	logic [1:0]  mid_s;
	logic [1:0]  low_s;
	logic [1:0]  cu_sel_s;
	logic [1:0]  fo_sel_s;
	logic [1:0]  speed_s;
	logic [1:0]  duplex_s;

	logic        por_d_r;
	logic        pd_n_d_r;
	logic        soft_d_r;
	logic        trigger;
	logic [mcm_pkg::WAIT_W-1:0] wait_r;
	logic        strap_load_r;
	logic        addr_hi_r;

	logic [15:0] op_mode_r;
	logic [15:0] strap_a_r;
	logic [15:0] strap_b_r;
	logic [15:0] op_mode_nxt;
	logic [15:0] mode_view;
	logic [15:0] rd_data;

	logic [4:0]  reg_addr;
	logic [15:0] wr_data;
	logic        wr_stb;

	// All pins cross in through two flip-flops. Multi-bit straps may skew by a
	// cycle, which is harmless because the latched ones are sampled microseconds after settling.
	assign raw = {mdc_i, mdio_i, por_i, power_down_n_i, copper_tx_off_n_i,
	              fiber_tx_off_n_i, backup_link_sel_i, addr_strap_upper_i,
	              addr_strap_mid_i, addr_strap_low_i, copper_iface_select_i,
	              fiber_iface_select_i, speed_strap_i, duplex_strap_i};

	genvar gi;
	generate
		for (gi = 0; gi < mcm_pkg::SYNC_W; gi++) begin : g_sync
			// One two-stage synchroniser per pin bit.
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// Second-stage names for the rest of the logic.
	assign {mdc_s, mdio_s, por_s, pd_n_s, cu_off_n_s, fo_off_n_s, backup_s,
	        up_s, mid_s, low_s, cu_sel_s, fo_sel_s, speed_s, duplex_s} = sync2_r;

	// Delayed copies for edge detection of the latch triggers.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			por_d_r  <= 1'b0;
			pd_n_d_r <= 1'b0;
			soft_d_r <= 1'b0;
		end else begin
			por_d_r  <= por_s;
			pd_n_d_r <= pd_n_s;
			soft_d_r <= op_mode_r[mcm_pkg::OM_SOFT_RST];
		end
	end

	// Any of the three events starts or restarts the strap delay.
	assign trigger = (por_d_r & ~por_s) |
	                 (~pd_n_d_r & pd_n_s) |
	                 (soft_d_r & ~op_mode_r[mcm_pkg::OM_SOFT_RST]);

	// Strap delay counter; sampling at the short end keeps latency low while
	// still inside the window whatever the trigger.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wait_r       <= '0;
			strap_load_r <= 1'b0;
		end else begin
			strap_load_r <= 1'b0;
			if (trigger) begin
				wait_r <= mcm_pkg::WAIT_W'(mcm_pkg::STRAP_WAIT_CYC);
			end else if (wait_r != '0) begin
				wait_r <= wait_r - 1'b1;
				if (wait_r == mcm_pkg::WAIT_W'(1)) strap_load_r <= 1'b1;
			end
		end
	end

	// Upper address strap is caught with the other straps; the mid and low
	// address pins are read live, so the board must keep them still.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			addr_hi_r <= 1'b0;
		end else if (strap_load_r) begin
			addr_hi_r <= up_s[0];
		end
	end

	// Five address bits: one from the upper pin and two from each other pin.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			station_address_o <= 5'h00;
		end else begin
			station_address_o <= {addr_hi_r, mid_s, low_s};
		end
	end

	// Speed and duplex straps decoded to operating mode control bits.
	always_comb begin
		op_mode_nxt = mcm_pkg::OP_MODE_RST;
		unique case (speed_s)
			mcm_pkg::LVL3_LOW: begin
				op_mode_nxt[mcm_pkg::OM_DSBL_AN]    = 1'b1;
				op_mode_nxt[mcm_pkg::OM_SINGLE_SPD] = 1'b1;
				op_mode_nxt[mcm_pkg::OM_SEL10]      = 1'b1;
			end
			mcm_pkg::LVL3_HIGH: begin
				op_mode_nxt[mcm_pkg::OM_DSBL_AN]    = 1'b1;
				op_mode_nxt[mcm_pkg::OM_SINGLE_SPD] = 1'b1;
			end
			default: begin
			end
		endcase
		// A floating duplex pin keeps the transparent default.
		unique case (duplex_s)
			mcm_pkg::LVL3_LOW: begin
				op_mode_nxt[mcm_pkg::OM_TRANSP_N] = 1'b1;
				op_mode_nxt[mcm_pkg::OM_ADV_FD_N] = 1'b1;
			end
			mcm_pkg::LVL3_HIGH: begin
				op_mode_nxt[mcm_pkg::OM_TRANSP_N] = 1'b1;
			end
			default: begin
			end
		endcase
	end

	// Operating mode control: strap load first, then management writes; the
	// soft reset bit clears itself one cycle later, which fires the reload.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_mode_r <= mcm_pkg::OP_MODE_RST;
		end else if (strap_load_r) begin
			op_mode_r <= op_mode_nxt;
		end else if (wr_stb && reg_addr == mcm_pkg::REG_OP_MODE) begin
			op_mode_r <= wr_data & mcm_pkg::OP_MODE_WM;
		end else if (op_mode_r[mcm_pkg::OM_SOFT_RST]) begin
			op_mode_r[mcm_pkg::OM_SOFT_RST] <= 1'b0;
		end
	end

	// Strap control A: transmitter off, backup link and warning enable.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_a_r <= mcm_pkg::STRAP_A_RST;
		end else if (strap_load_r) begin
			strap_a_r <= mcm_pkg::STRAP_A_RST;
			strap_a_r[mcm_pkg::SA_LIW] <= up_s[1];
		end else if (wr_stb && reg_addr == mcm_pkg::REG_STRAP_A) begin
			strap_a_r <= wr_data & mcm_pkg::STRAP_A_WM;
		end
	end

	// Strap control B: the two four-level interface selections.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_b_r <= mcm_pkg::STRAP_B_RST;
		end else if (strap_load_r) begin
			strap_b_r <= mcm_pkg::STRAP_B_RST;
			strap_b_r[mcm_pkg::SB_CU_SEL +: 2] <= cu_sel_s;
			strap_b_r[mcm_pkg::SB_FO_SEL +: 2] <= fo_sel_s;
		end else if (wr_stb && reg_addr == mcm_pkg::REG_STRAP_B) begin
			strap_b_r <= wr_data & mcm_pkg::STRAP_B_WM;
		end
	end

	// Mode decode from the control bits in force.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_mode_o <= mcm_pkg::MCM_TRANSP;
		end else if (op_mode_r[mcm_pkg::OM_DSBL_AN] &&
		             op_mode_r[mcm_pkg::OM_SINGLE_SPD]) begin
			op_mode_o <= op_mode_r[mcm_pkg::OM_SEL10] ?
			             mcm_pkg::MCM_FORCED10 : mcm_pkg::MCM_FORCED100;
		end else if (op_mode_r[mcm_pkg::OM_SINGLE_SPD]) begin
			op_mode_o <= mcm_pkg::MCM_NT_SPECIAL;
		end else if (!op_mode_r[mcm_pkg::OM_TRANSP_N]) begin
			op_mode_o <= mcm_pkg::MCM_TRANSP;
		end else begin
			op_mode_o <= op_mode_r[mcm_pkg::OM_ADV_FD_N] ?
			             mcm_pkg::MCM_NT_HALF : mcm_pkg::MCM_NT_FULL;
		end
	end

	// Special modes: pins and register bits combine, either can request; the two loopbacks come from register bits only.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			power_down_o    <= 1'b0;
			loop_fiber_o    <= 1'b0;
			loop_copper_o   <= 1'b0;
			copper_tx_off_o <= 1'b0;
			fiber_tx_off_o  <= 1'b0;
			backup_link_o   <= 1'b0;
		end else begin
			power_down_o    <= ~pd_n_s | op_mode_r[mcm_pkg::OM_PWR_DOWN];
			loop_fiber_o    <= op_mode_r[mcm_pkg::OM_LOOP_FO];
			loop_copper_o   <= op_mode_r[mcm_pkg::OM_LOOP_CU];
			copper_tx_off_o <= ~cu_off_n_s | strap_a_r[mcm_pkg::SA_CU_OFF];
			fiber_tx_off_o  <= ~fo_off_n_s | strap_a_r[mcm_pkg::SA_FO_OFF];
			backup_link_o   <= backup_s | strap_a_r[mcm_pkg::SA_BACKUP];
		end
	end

	// Interface modes and link warning enable, straight from control.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			copper_iface_o <= 2'h0;
			fiber_iface_o  <= 2'h0;
			liw_enable_o   <= 1'b0;
		end else begin
			copper_iface_o <= strap_b_r[mcm_pkg::SB_CU_SEL +: 2];
			fiber_iface_o  <= strap_b_r[mcm_pkg::SB_FO_SEL +: 2];
			liw_enable_o   <= strap_a_r[mcm_pkg::SA_LIW];
		end
	end

	// Status view built from the registered outputs, so it shows what is in force.
	always_comb begin
		mode_view = 16'h0000;
		mode_view[mcm_pkg::MV_ADDR +: 5] = station_address_o;
		mode_view[mcm_pkg::MV_MODE +: 3] = op_mode_o;
		mode_view[mcm_pkg::MV_PD]        = power_down_o;
		mode_view[mcm_pkg::MV_CU_OFF]    = copper_tx_off_o;
		mode_view[mcm_pkg::MV_FO_OFF]    = fiber_tx_off_o;
		mode_view[mcm_pkg::MV_BACKUP]    = backup_link_o;
		mode_view[mcm_pkg::MV_LOOP_FO]   = loop_fiber_o;
		mode_view[mcm_pkg::MV_LOOP_CU]   = loop_copper_o;
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		unique case (reg_addr)
			mcm_pkg::REG_MODE_VIEW: rd_data = mode_view;
			mcm_pkg::REG_STRAP_A:   rd_data = strap_a_r;
			mcm_pkg::REG_OP_MODE:   rd_data = op_mode_r;
			mcm_pkg::REG_STRAP_B:   rd_data = strap_b_r;
			default:                rd_data = 16'h0000;
		endcase
	end

	// Frame slave on the synchronised clock; at 200 MHz the two-flop path
	// leaves ample margin for a 12.5 MHz management clock.
	mcm_mdio_slave u_slave (
		.clk_i             (clk_i),
		.sys_rst_i         (sys_rst_i),
		.mdc_i             (mdc_s),
		.mdio_i            (mdio_s),
		.station_address_i (station_address_o),
		.rd_data_i         (rd_data),
		.reg_addr_o        (reg_addr),
		.wr_data_o         (wr_data),
		.wr_stb_o          (wr_stb),
		.mdio_o            (mdio_o),
		.mdio_oe_o         (mdio_oe_o)
	);

endmodule // mcm_config_mgmt
`default_nettype wire

// *** include/mcm_pkg.sv ***
// Constants, register map and mode encodings for the media converter config block.
package mcm_pkg;

	// Clock rate and strap sampling delay.
	localparam int CLK_MHZ        = 200;
	localparam int STRAP_MIN_NS   = 3000;
	localparam int STRAP_WAIT_CYC = (STRAP_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int WAIT_W         = 11;

	// Management register addresses.
	localparam logic [4:0] REG_MODE_VIEW = 5'h1b;
	localparam logic [4:0] REG_STRAP_A   = 5'h1c;
	localparam logic [4:0] REG_OP_MODE   = 5'h1e;
	localparam logic [4:0] REG_STRAP_B   = 5'h1f;

	// Operating mode control field positions.
	localparam int OM_ADV_HD_N   = 15;
	localparam int OM_DSBL_AN    = 14;
	localparam int OM_SOFT_RST   = 13;
	localparam int OM_TRANSP_N   = 11;
	localparam int OM_ADV_FD_N   = 10;
	localparam int OM_SINGLE_SPD = 9;
	localparam int OM_SEL10      = 8;
	localparam int OM_LOOP_CU    = 2;
	localparam int OM_LOOP_FO    = 1;
	localparam int OM_PWR_DOWN   = 0;

	// Strap control A and B field positions.
	localparam int SA_CU_OFF   = 0;
	localparam int SA_FO_OFF   = 1;
	localparam int SA_BACKUP   = 2;
	localparam int SA_LIW      = 3;
	localparam int SB_CU_SEL   = 0;
	localparam int SB_FO_SEL   = 2;

	// Mode status view field positions.
	localparam int MV_ADDR     = 0;
	localparam int MV_MODE     = 5;
	localparam int MV_PD       = 8;
	localparam int MV_CU_OFF   = 9;
	localparam int MV_FO_OFF   = 10;
	localparam int MV_BACKUP   = 11;
	localparam int MV_LOOP_FO  = 12;
	localparam int MV_LOOP_CU  = 13;

	// Reset values and writable masks.
	localparam logic [15:0] OP_MODE_RST = 16'h0000;
	localparam logic [15:0] STRAP_A_RST = 16'h0000;
	localparam logic [15:0] STRAP_B_RST = 16'h0000;
	localparam logic [15:0] OP_MODE_WM  = 16'hef07;
	localparam logic [15:0] STRAP_A_WM  = 16'h000f;
	localparam logic [15:0] STRAP_B_WM  = 16'h000f;

	// Three-level strap codes from the pin comparators.
	localparam logic [1:0] LVL3_LOW  = 2'h0;
	localparam logic [1:0] LVL3_HIGH = 2'h2;

	// Management frame fields.
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;
	localparam logic [4:0] OP_BITS      = 5'h02;
	localparam logic [4:0] ADR_BITS     = 5'h0a;
	localparam logic [4:0] DATA_BITS    = 5'h10;

	// Synchroniser bank width.
	localparam int SYNC_W = 21;

	typedef enum logic [2:0] {
		MCM_FORCED10,
		MCM_FORCED100,
		MCM_NT_HALF,
		MCM_NT_FULL,
		MCM_TRANSP,
		MCM_NT_SPECIAL
	} mcm_mode_e;

endpackage

// *** verilog/mcm_mdio_slave.sv ***
// Management frame slave: decodes frames, issues writes, serves reads.
`timescale 1ns/10ps
`default_nettype none
module mcm_mdio_slave (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	input  wire logic [4:0]  station_address_i,
	input  wire logic [15:0] rd_data_i,
	output logic      [4:0]  reg_addr_o,
	output logic      [15:0] wr_data_o,
	output logic             wr_stb_o,
	output logic             mdio_o,
	output logic             mdio_oe_o
);

	typedef enum logic [2:0] {
		MS_PRE, MS_ST, MS_OP, MS_ADR, MS_TA, MS_WDAT, MS_RDAT
	} mcm_ms_e;

	mcm_ms_e     state_r;
	logic        mdc_d_r;
	logic [5:0]  ones_r;
	logic [4:0]  cnt_r;
	logic [1:0]  op_r;
	logic [9:0]  adr_r;
	logic [15:0] sh_r;
	logic        rise;

	// Inputs arrive already synchronised; only the edge is found here.
	assign rise = mdc_i & ~mdc_d_r;

	always_ff @(posedge clk_i) begin
		mdc_d_r <= sys_rst_i ? 1'b0 : mdc_i;
	end

	// Frame walker, one step per rising management clock edge.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r    <= MS_PRE;
			ones_r     <= 6'h00;
			cnt_r      <= 5'h00;
			op_r       <= 2'h0;
			adr_r      <= 10'h000;
			sh_r       <= 16'h0000;
			wr_stb_o   <= 1'b0;
			wr_data_o  <= 16'h0000;
			reg_addr_o <= 5'h00;
			mdio_o     <= 1'b0;
			mdio_oe_o  <= 1'b0;
		end else begin
			wr_stb_o <= 1'b0;
			if (rise) begin
				unique case (state_r)
					MS_PRE: begin
						if (mdio_i) begin
							if (ones_r != mcm_pkg::PREAMBLE_LEN) ones_r <= ones_r + 6'h01;
						end else begin
							state_r <= (ones_r == mcm_pkg::PREAMBLE_LEN) ? MS_ST : MS_PRE;
							ones_r  <= 6'h00;
						end
					end
					MS_ST: begin
						state_r <= mdio_i ? MS_OP : MS_PRE;
						cnt_r   <= 5'h00;
					end
					MS_OP: begin
						op_r  <= {op_r[0], mdio_i};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == mcm_pkg::OP_BITS - 5'h01) begin
							state_r <= MS_ADR;
							cnt_r   <= 5'h00;
						end
					end
					MS_ADR: begin
						adr_r <= {adr_r[8:0], mdio_i};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == mcm_pkg::ADR_BITS - 5'h01) begin
							cnt_r      <= 5'h00;
							reg_addr_o <= {adr_r[3:0], mdio_i};
							// Foreign address or opcode: stay silent and hunt again.
							if (adr_r[8:4] == station_address_i &&
							    (op_r == mcm_pkg::OP_READ ||
							     op_r == mcm_pkg::OP_WRITE)) begin
								state_r <= MS_TA;
							end else begin
								state_r <= MS_PRE;
							end
						end
					end
					MS_TA: begin
						cnt_r <= cnt_r + 5'h01;
						if (op_r == mcm_pkg::OP_READ) begin
							// First turnaround bit is left to float; drive zero now.
							mdio_oe_o <= 1'b1;
							mdio_o    <= 1'b0;
							sh_r      <= rd_data_i;
							cnt_r     <= 5'h00;
							state_r   <= MS_RDAT;
						end else if (cnt_r == 5'h01) begin
							cnt_r   <= 5'h00;
							state_r <= MS_WDAT;
						end
					end
					MS_WDAT: begin
						sh_r  <= {sh_r[14:0], mdio_i};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == mcm_pkg::DATA_BITS - 5'h01) begin
							wr_data_o <= {sh_r[14:0], mdio_i};
							wr_stb_o  <= 1'b1;
							state_r   <= MS_PRE;
						end
					end
					MS_RDAT: begin
						if (cnt_r == mcm_pkg::DATA_BITS) begin
							mdio_oe_o <= 1'b0;
							state_r   <= MS_PRE;
						end else begin
							mdio_o <= sh_r[15];
							sh_r   <= {sh_r[14:0], 1'b0};
							cnt_r  <= cnt_r + 5'h01;
						end
					end
				endcase
			end
		end
	end

endmodule // mcm_mdio_slave
`default_nettype wire

// *** sim/mcm_sva.sv ***
// Pin-level assertions for the media converter configuration block.
`timescale 1ns/10ps
`default_nettype none
module mcm_sva (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic       mdc_i,
	input wire logic       mdio_o,
	input wire logic       mdio_oe_o,
	input wire logic [1:0] addr_strap_mid_i,
	input wire logic [1:0] addr_strap_low_i,
	input wire logic       power_down_n_i,
	input wire logic       copper_tx_off_n_i,
	input wire logic       fiber_tx_off_n_i,
	input wire logic       backup_link_sel_i,
	input wire logic [4:0] station_address_o,
	input wire logic [1:0] copper_iface_o,
	input wire logic       power_down_o,
	input wire logic       copper_tx_off_o,
	input wire logic       fiber_tx_off_o,
	input wire logic       backup_link_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Cycles since the power-down pin rose; it saturates so a long idle never wraps.
	logic [9:0] pd_cnt_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			pd_cnt_r <= 10'h3ff;
		else if ($rose(power_down_n_i))
			pd_cnt_r <= 10'h000;
		else if (pd_cnt_r != 10'h3ff)
			pd_cnt_r <= pd_cnt_r + 10'h001;
	end

	// The copper interface select may not move before the earliest sampling time.
	a_strap_early_hold: assert property (pd_cnt_r < 10'h24e |-> $stable(copper_iface_o))
		else $error("interface select changed too soon after a trigger");
	// Active pins override the register bits after the synchroniser delay.
	a_cu_pin_off: assert property ((!copper_tx_off_n_i) [*3] |=> copper_tx_off_o)
		else $error("copper transmitter stayed on with its pin low");
	a_fo_pin_off: assert property ((!fiber_tx_off_n_i) [*3] |=> fiber_tx_off_o)
		else $error("fiber transmitter stayed on with its pin low");
	a_pd_pin_down: assert property ((!power_down_n_i) [*3] |=> power_down_o)
		else $error("power down not entered with its pin low");
	a_backup_pin_on: assert property (backup_link_sel_i [*3] |=> backup_link_o)
		else $error("backup link not enabled with its pin high");
	a_addr_low_live: assert property (
		$stable({addr_strap_mid_i, addr_strap_low_i}) [*4]
		|=> station_address_o[3:0] == $past({addr_strap_mid_i, addr_strap_low_i}))
		else $error("station address does not follow the address straps");
	// The read answer moves only in MDC high phases, starting with a low turnaround bit.
	a_ta_drive_zero: assert property ($rose(mdio_oe_o) |-> mdc_i && !mdio_o)
		else $error("turnaround not driven low in an MDC high phase");
	a_data_on_mdc: assert property (
		mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |-> mdc_i)
		else $error("read data moved outside an MDC high phase");
	a_oe_release: assert property ($fell(mdio_oe_o) |-> mdc_i)
		else $error("data line released outside an MDC high phase");

	// Main scenarios reached.
	c_read_answered: cover property ($rose(mdio_oe_o));
	c_strap_window: cover property (pd_cnt_r == 10'h258);
	c_pin_override: cover property ($rose(copper_tx_off_o));
endmodule // mcm_sva

bind mcm_config_mgmt mcm_sva i_sva (
	.clk_i, .sys_rst_i, .mdc_i, .mdio_o, .mdio_oe_o, .addr_strap_mid_i, .addr_strap_low_i,
	.power_down_n_i, .copper_tx_off_n_i, .fiber_tx_off_n_i, .backup_link_sel_i,
	.station_address_o, .copper_iface_o, .power_down_o, .copper_tx_off_o, .fiber_tx_off_o,
	.backup_link_o
);
`default_nettype wire

// *** sim/mcm_mgmt_host.sv ***
// Station management controller model that runs clause-22 frames.
`timescale 1ns/10ps
`default_nettype none
module mcm_mgmt_host (
	input  wire logic clk_i,
	input  wire logic mdio_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_oe_o
);
	// MDC stands low between frames and the data line is released.
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end

	// Eight reference cycles per half period give the fastest allowed MDC.
	task automatic half();
		repeat (8) @(posedge clk_i);
		#1;
	endtask

	// Data changes while MDC is low; the line is sampled before being driven.
	task automatic bit_cyc(input logic oe, input logic d, output logic smp);
		mdc_o = 1'b0;
		smp = mdio_i;
		mdio_oe_o = oe;
		mdio_o = d;
		half();
		mdc_o = 1'b1;
		half();
	endtask

	// Whole frame with its own preamble; reads release the line from the turnaround on.
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rd, output logic ta0);
		logic [45:0] hdr;
		logic        s;
		logic        wr;
		hdr = {32'hffffffff, 2'h1, op, phy, ra};
		wr = (op == 2'h1);
		for (int i = 45; i >= 0; i--)
			bit_cyc(1'b1, hdr[i], s);
		bit_cyc(wr, 1'b1, s);
		bit_cyc(wr, 1'b0, ta0);
		for (int i = 15; i >= 0; i--)
			bit_cyc(wr, wd[i], rd[i]);
		mdc_o = 1'b0;
		mdio_oe_o = 1'b0;
		half();
	endtask
endmodule // mcm_mgmt_host
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the media converter configuration block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk, rst, por, pd_n, cu_n, fo_n, bk, ta;
	logic [1:0]  up, md, lo, sp, dp, cu, fo, cu_o, fo_o;
	logic        mdio_o, mdio_oe, h_mdc, h_d, h_oe, mdio_w;
	logic        liw, pd_o, lp_fo, lp_cu, cu_off, fo_off, bk_o;
	logic [4:0]  st_addr, adr;
	logic [2:0]  op_mode;
	logic [15:0] wd, wa, wb, rd;
	int          err_count = 0;
	int          cmp_count = 0;
	int          seed = 32'h08de;
	logic [15:0] mtab [6] = '{16'h4300, 16'h4200, 16'h0c00, 16'h0800, 16'h0000, 16'h0200};

	// Address bit 4 is latched at strap load, the rest follow the pins.
	assign adr = {up[0], md, lo};
	// The line has a pull-up, so a released line reads high.
	assign mdio_w = mdio_oe ? mdio_o : (h_oe ? h_d : 1'b1);

	mcm_config_mgmt i_dut (
		.clk_i(clk), .sys_rst_i(rst), .por_i(por), .mdc_i(h_mdc), .mdio_i(mdio_w),
		.mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .addr_strap_upper_i(up), .addr_strap_mid_i(md),
		.addr_strap_low_i(lo), .speed_strap_i(sp), .duplex_strap_i(dp),
		.copper_iface_select_i(cu), .fiber_iface_select_i(fo), .power_down_n_i(pd_n),
		.copper_tx_off_n_i(cu_n), .fiber_tx_off_n_i(fo_n), .backup_link_sel_i(bk),
		.station_address_o(st_addr), .op_mode_o(op_mode), .liw_enable_o(liw),
		.copper_iface_o(cu_o), .fiber_iface_o(fo_o), .power_down_o(pd_o),
		.loop_fiber_o(lp_fo), .loop_copper_o(lp_cu), .copper_tx_off_o(cu_off),
		.fiber_tx_off_o(fo_off), .backup_link_o(bk_o)
	);
	mcm_mgmt_host i_host (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(h_mdc), .mdio_o(h_d),
		.mdio_oe_o(h_oe));

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Expected control register after a strap load, from speed and duplex levels.
	function automatic logic [15:0] strap_op(input logic [1:0] s, input logic [1:0] d);
		strap_op = 16'h0000;
		if (s == mcm_pkg::LVL3_LOW) strap_op = 16'h4300;
		if (s == mcm_pkg::LVL3_HIGH) strap_op = 16'h4200;
		if (d == mcm_pkg::LVL3_LOW) strap_op |= 16'h0c00;
		if (d == mcm_pkg::LVL3_HIGH) strap_op |= 16'h0800;
	endfunction

	// Operating mode in force for a given control register value.
	function automatic logic [2:0] mode_of(input logic [15:0] r);
		if (r[14] && r[9]) mode_of = r[8] ? mcm_pkg::MCM_FORCED10 : mcm_pkg::MCM_FORCED100;
		else if (r[9]) mode_of = mcm_pkg::MCM_NT_SPECIAL;
		else if (!r[11]) mode_of = mcm_pkg::MCM_TRANSP;
		else mode_of = r[10] ? mcm_pkg::MCM_NT_HALF : mcm_pkg::MCM_NT_FULL;
	endfunction

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Straps stay untouched for the whole frame, as the board must keep them.
	task automatic mrd(input logic [4:0] ra, input logic [15:0] e, input string nm);
		i_host.frame(mcm_pkg::OP_READ, adr, ra, 16'h0000, rd, ta);
		chk("turnaround", 16'h0000, 16'(ta));
		chk(nm, e, rd);
	endtask

	// Extra cycles let the write reach the register and the outputs.
	task automatic mwr(input logic [4:0] ra, input logic [15:0] d);
		i_host.frame(mcm_pkg::OP_WRITE, adr, ra, d, rd, ta);
		repeat (4) tick();
	endtask

	task automatic chk_straps();
		chk("strap mode", 16'(mode_of(strap_op(sp, dp))), 16'(op_mode));
		chk("strap iface", {12'h000, fo, cu}, {12'h000, fo_o, cu_o});
		chk("strap addr", {11'h000, adr}, {11'h000, st_addr});
		chk("strap liw", 16'(up[1]), 16'(liw));
	endtask

	task automatic results();
		$display("Comparisons %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// The run takes about 340 us; 450 us (90000 cycles) means a hang.
	initial begin
		#450000;
		err_count++;
		results();
	end

	// Main sequence: reset, strap loads, register traffic, refusals, pins, soft reset.
	initial begin
		{rst, por, pd_n, cu_n, fo_n, bk} = 6'h3e;
		{up, md, lo, cu, fo} = 10'($random(seed));
		{sp, dp} = 4'h5;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		por = 1'b0;
		chk("reset outputs", 16'h0100, 16'({op_mode, liw, cu_o, fo_o, mdio_oe}));
		repeat (620) tick();
		chk_straps();
		for (int s = 0; s < 9; s++) begin
			{up, md, lo, cu, fo} = 10'($random(seed));
			sp = (s % 3 == 1 && s > 4) ? 2'h3 : 2'(s % 3);
			dp = 2'(s / 3);
			pd_n = 1'b0;
			repeat (5) tick();
			chk("pd pin", 16'h0001, 16'(pd_o));
			pd_n = 1'b1;
			repeat (620) tick();
			chk_straps();
		end
		// A power-on reset pulse alone must reload, with the power-down pin high.
		{up, md, lo, cu, fo} = 10'($random(seed));
		por = 1'b1;
		repeat (4) tick();
		por = 1'b0;
		repeat (620) tick();
		chk_straps();
		for (int i = 0; i < 6; i++) begin
			wd = mtab[i] | (16'($random(seed)) & 16'h90f7);
			wa = 16'($random(seed));
			wb = 16'($random(seed));
			mwr(mcm_pkg::REG_OP_MODE, wd);
			mrd(mcm_pkg::REG_OP_MODE, wd & mcm_pkg::OP_MODE_WM, "op reg");
			chk("mode outs", 16'({mode_of(wd), wd[0], wd[1], wd[2]}),
				16'({op_mode, pd_o, lp_fo, lp_cu}));
			mwr(mcm_pkg::REG_STRAP_A, wa);
			mrd(mcm_pkg::REG_STRAP_A, wa & mcm_pkg::STRAP_A_WM, "strap a reg");
			chk("strap a outs", 16'({wa[2], wa[1], wa[0], wa[3]}),
				16'({bk_o, fo_off, cu_off, liw}));
			mwr(mcm_pkg::REG_STRAP_B, wb);
			mrd(mcm_pkg::REG_STRAP_B, wb & mcm_pkg::STRAP_B_WM, "strap b reg");
			chk("iface outs", 16'(wb[3:0]), 16'({fo_o, cu_o}));
			mwr(mcm_pkg::REG_MODE_VIEW, ~wd);
			mrd(mcm_pkg::REG_MODE_VIEW, {2'h0, wd[2], wd[1], wa[2], wa[1], wa[0], wd[0],
				mode_of(wd), adr}, "mode view");
		end
		mwr(5'h05, 16'hffff);
		mrd(5'h05, 16'h0000, "unmapped");
		for (int k = 0; k < 3; k++) begin
			i_host.frame(k == 0 ? mcm_pkg::OP_READ : (k == 1 ? 2'h0 : 2'h3),
				k == 0 ? adr ^ 5'h10 : adr, mcm_pkg::REG_OP_MODE, 16'h0000, rd, ta);
			chk("refused frame", 16'hffff, rd);
		end
		mwr(mcm_pkg::REG_STRAP_A, 16'h0000);
		mwr(mcm_pkg::REG_OP_MODE, 16'h0000);
		{pd_n, cu_n, fo_n, bk} = 4'h1;
		repeat (4) tick();
		chk("pins on", 16'h000f, 16'({pd_o, cu_off, fo_off, bk_o}));
		{pd_n, cu_n, fo_n, bk} = 4'he;
		repeat (4) tick();
		chk("pins off", 16'h0000, 16'({pd_o, cu_off, fo_off, bk_o}));
		mwr(mcm_pkg::REG_OP_MODE, 16'h2006);
		repeat (620) tick();
		mrd(mcm_pkg::REG_OP_MODE, strap_op(sp, dp), "soft reset reload");
		results();
	end
endmodule // testbench
`default_nettype wire
